// >>> alpo_pkg.sv
// package: constants for the absolute linear position output block
package alpo_pkg;
  localparam int          CLK_HZ          = 10000000;
  localparam int          BAUD_BPS        = 9600;
  // bit period rounds down to whole cycles
  localparam int          BIT_CYCLES      = CLK_HZ / BAUD_BPS;
  localparam int          BIT_CNT_W       = 11;
  localparam int          POS_W           = 36;
  localparam int          UPPER_W         = 16;
  localparam int          LOWER_W         = 20;
  localparam int          CHAR_W          = 7;
  localparam int          FRAME_BITS      = 10;
  localparam int          MSG_LEN         = 8;
  localparam int          ALM_LEN         = 6;
  localparam int          FIFO_W          = 7;
  localparam int          FIFO_D          = 8;
  localparam int          QUAD_CYCLES     = 4;
  localparam logic [6:0]  CH_P            = 7'h50;
  localparam logic [6:0]  CH_PLUS         = 7'h2B;
  localparam logic [6:0]  CH_MINUS        = 7'h2D;
  localparam logic [6:0]  CH_ZERO         = 7'h30;
  localparam logic [6:0]  CH_CR           = 7'h0D;
  localparam logic [6:0]  CH_A            = 7'h41;
  localparam logic [6:0]  CH_L            = 7'h4C;
  localparam logic [6:0]  CH_M            = 7'h4D;
  localparam logic [1:0]  USAGE_ABSOLUTE  = 2'h0;
  localparam logic [1:0]  USAGE_INCREMENT = 2'h1;
endpackage

// >>> alpo_stream_if.sv
// interface: character stream between message builder and fifo
`timescale 1ns/10ps
interface alpo_stream_if;
  logic [6:0] data;
  logic       valid;
  logic       ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// >>> alpo_fifo.sv
// module: parameterised valid/ready fifo
`timescale 1ns/10ps
module alpo_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  alpo_stream_if.sink           inPort,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inPort.ready = (count != (AW+1)'(DEPTH));
  assign outValid     = (count != '0);
  assign outData      = mem[rdPtr];
  assign doWr         = inPort.valid && inPort.ready;
  assign doRd         = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inPort.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule

// >>> alpo_position_output.sv
// module: absolute linear position output on divided pulse lines
// Function
// - position is a signed 36-bit pulse count from encoder origin.
// - position goes out as signed upper 16 bits and unsigned lower 20 bits.
// - after the serial message, lower 20 bits go out as a pulse train.
// - after the transfer, phases A and B carry ordinary incremental quadrature.
// - phase B carries only the lower pulse train during the first transfer.
// - only phase A toggles while the serial message is sent.
// - sequence starts on each sensor-on command after control power up, in absolute usage only.
// - serial framing 9600 bps, start bit, 7-bit ASCII, even parity, stop bit.
// - message is P, sign, five decimal digits, carriage return.
// - both portions come from the position scaled by divided-output resolution.
// - usage digit 0 absolute, 1 incremental, latched only at restart.
// - on sensor-on falling, send alarm as A, L, M, two digits, CR.
`timescale 1ns/10ps
module alpo_position_output (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [35:0] encoderPosition,
  input  wire logic [15:0] divided_output_resolution_setting,
  input  wire logic [1:0]  encoder_usage_setting,
  input  wire logic        direction_selection_setting,
  input  wire logic        sensor_power_on_command,
  input  wire logic        sensor_power_off_command,
  input  wire logic        alarmActive,
  input  wire logic [7:0]  alarmCode,
  input  wire logic        originPulse,
  output      logic        divided_phase_a_out,
  output      logic        divided_phase_b_out,
  output      logic        divided_origin_pulse_out,
  output      logic        transferBusy
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_LOAD  = 6'b000010,
    ST_SER   = 6'b000100,
    ST_PULSE = 6'b001000,
    ST_INCR  = 6'b010000,
    ST_ALARM = 6'b100000
  } alpo_state_t;

  // ============================================================
  // input synchronisers
  logic [1:0]  senOnSync;
  logic [1:0]  senOffSync;
  logic [1:0]  origSync;
  logic        senOnPrev;
  logic        senOffPrev;
  logic        senOnRise;
  logic        senOnFall;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      senOnSync  <= 2'h0;
      senOffSync <= 2'h0;
      origSync   <= 2'h0;
      senOnPrev  <= 1'b0;
      senOffPrev <= 1'b0;
    end else begin
      senOnSync  <= {senOnSync[0], sensor_power_on_command};
      senOffSync <= {senOffSync[0], sensor_power_off_command};
      origSync   <= {origSync[0], originPulse};
      senOnPrev  <= senOnSync[1];
      senOffPrev <= senOffSync[1];
    end
  end
  assign senOnRise = senOnSync[1] && !senOnPrev;
  // sensor-off edge also ends sensor-on; a held level would resend the alarm
  assign senOnFall = (!senOnSync[1] && senOnPrev) || (senOffSync[1] && !senOffPrev);

  // ============================================================
  // usage latched once after restart
  logic       usageLatched;
  logic [1:0] usage;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      usageLatched <= 1'b0;
      usage        <= alpo_pkg::USAGE_ABSOLUTE;
    end else if (!usageLatched) begin
      usageLatched <= 1'b1;
      usage        <= encoder_usage_setting;
    end
  end

  // ============================================================
  // scaling and message building
  function automatic logic [6:0] digitChar(input logic [16:0] v, input int pw);
    logic [16:0] q;
    q = 17'h0;
    case (pw)
      4:       q = v / 17'd10000;
      3:       q = (v / 17'd1000) % 17'd10;
      2:       q = (v / 17'd100) % 17'd10;
      1:       q = (v / 17'd10) % 17'd10;
      default: q = v % 17'd10;
    endcase
    return alpo_pkg::CH_ZERO + q[6:0];
  endfunction

  alpo_state_t state;
  logic [35:0] scaledPos;
  logic [19:0] lowerPart;
  logic [16:0] upperMag;
  logic        upperNeg;
  logic [3:0]  charIdx;
  logic [6:0]  nextChar;
  logic [3:0]  msgLen;
  logic        serDone;

  alpo_stream_if charStream ();

  always_comb begin
    logic signed [15:0] up;
    up       = scaledPos[35:20];
    upperNeg = up[15];
    upperMag = up[15] ? 17'(-$signed({up[15], up})) : {1'b0, up};
  end

  always_comb begin
    nextChar = alpo_pkg::CH_CR;
    if (state == ST_ALARM) begin
      case (charIdx)
        4'h0:    nextChar = alpo_pkg::CH_A;
        4'h1:    nextChar = alpo_pkg::CH_L;
        4'h2:    nextChar = alpo_pkg::CH_M;
        4'h3:    nextChar = alpo_pkg::CH_ZERO + 7'(alarmCode[7:4] % 4'hA);
        4'h4:    nextChar = alpo_pkg::CH_ZERO + 7'(alarmCode[3:0] % 4'hA);
        default: nextChar = alpo_pkg::CH_CR;
      endcase
    end else begin
      case (charIdx)
        4'h0:    nextChar = alpo_pkg::CH_P;
        4'h1:    nextChar = upperNeg ? alpo_pkg::CH_MINUS : alpo_pkg::CH_PLUS;
        4'h2:    nextChar = digitChar(upperMag, 4);
        4'h3:    nextChar = digitChar(upperMag, 3);
        4'h4:    nextChar = digitChar(upperMag, 2);
        4'h5:    nextChar = digitChar(upperMag, 1);
        4'h6:    nextChar = digitChar(upperMag, 0);
        default: nextChar = alpo_pkg::CH_CR;
      endcase
    end
  end
  assign msgLen          = (state == ST_ALARM) ? 4'(alpo_pkg::ALM_LEN) : 4'(alpo_pkg::MSG_LEN);
  assign charStream.data  = nextChar;
  assign charStream.valid = (state == ST_SER || state == ST_ALARM) && (charIdx < msgLen);

  logic [6:0] fifoData;
  logic       fifoValid;
  logic       fifoReady;

  alpo_fifo #(
    .WIDTH (alpo_pkg::FIFO_W),
    .DEPTH (alpo_pkg::FIFO_D)
  ) uFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inPort   (charStream.sink),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // ============================================================
  // uart transmitter, 9600 bps 7E1
  logic [10:0] baudCnt;
  logic [3:0]  bitIdx;
  logic [9:0]  shiftReg;
  logic        txActive;
  logic        txLine;

  assign fifoReady = !txActive;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      baudCnt  <= 11'h0;
      bitIdx   <= 4'h0;
      shiftReg <= 10'h3FF;
      txActive <= 1'b0;
    end else if (!txActive) begin
      if (fifoValid) begin
        // stop, even parity, data lsb first, start
        shiftReg <= {1'b1, ^fifoData, fifoData, 1'b0};
        txActive <= 1'b1;
        baudCnt  <= 11'h0;
        bitIdx   <= 4'h0;
      end
    end else if (baudCnt == 11'(alpo_pkg::BIT_CYCLES - 1)) begin
      baudCnt  <= 11'h0;
      shiftReg <= {1'b1, shiftReg[9:1]};
      if (bitIdx == 4'(alpo_pkg::FRAME_BITS - 1)) begin
        txActive <= 1'b0;
      end
      bitIdx <= bitIdx + 4'h1;
    end else begin
      baudCnt <= baudCnt + 11'h1;
    end
  end
  assign txLine  = shiftReg[0];
  assign serDone = (charIdx == msgLen) && !fifoValid && !txActive;

  // ============================================================
  // sequencer
  logic [19:0] pulsesLeft;
  logic [1:0]  quadPhase;
  logic [1:0]  quadDiv;
  logic        quadStep;
  logic [35:0] lastPos;
  logic        dirFwd;

  assign quadStep = (quadDiv == 2'(alpo_pkg::QUAD_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      quadDiv <= 2'h0;
    end else begin
      quadDiv <= quadDiv + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      charIdx    <= 4'h0;
      scaledPos  <= 36'h0;
      lowerPart  <= 20'h0;
      pulsesLeft <= 20'h0;
      quadPhase  <= 2'h0;
      lastPos    <= 36'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (senOnRise && usageLatched && usage == alpo_pkg::USAGE_ABSOLUTE) begin
            state <= ST_LOAD;
          end else if (senOnRise && usageLatched) begin
            lastPos   <= encoderPosition;
            quadPhase <= 2'h1;
            state     <= ST_INCR;
          end else if (senOnFall && alarmActive) begin
            charIdx <= 4'h0;
            state   <= ST_ALARM;
          end
        end
        ST_LOAD: begin
          // signed 36-bit count scaled by resolution
          scaledPos <= 36'($signed(encoderPosition) /
                           $signed({1'b0, (divided_output_resolution_setting == 16'h0) ?
                                   16'h1 : divided_output_resolution_setting}));
          lastPos   <= encoderPosition;
          charIdx   <= 4'h0;
          state     <= ST_SER;
        end
        ST_SER: begin
          if (charStream.valid && charStream.ready) begin
            charIdx <= charIdx + 4'h1;
          end
          if (serDone) begin
            lowerPart  <= scaledPos[19:0];
            pulsesLeft <= scaledPos[19:0];
            // resume from the idle line level, else the host counts a false step
            quadPhase  <= 2'h1;
            state      <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (pulsesLeft == 20'h0) begin
            state <= ST_INCR;
          end else if (quadStep) begin
            quadPhase  <= quadPhase + 2'h1;
            pulsesLeft <= pulsesLeft - 20'h1;
          end
        end
        ST_INCR: begin
          if (senOnFall) begin
            charIdx <= 4'h0;
            state   <= alarmActive ? ST_ALARM : ST_IDLE;
          end else if (quadStep && encoderPosition != lastPos) begin
            // reverse setting swaps count direction
            quadPhase <= (dirFwd ^ direction_selection_setting) ?
                         quadPhase + 2'h1 : quadPhase - 2'h1;
            lastPos   <= dirFwd ? lastPos + 36'h1 : lastPos - 36'h1;
          end
        end
        ST_ALARM: begin
          if (charStream.valid && charStream.ready) begin
            charIdx <= charIdx + 4'h1;
          end
          if (serDone) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign dirFwd = $signed(encoderPosition) > $signed(lastPos);

  // ============================================================
  // output drivers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      divided_phase_a_out      <= 1'b1;
      divided_phase_b_out      <= 1'b0;
      divided_origin_pulse_out <= 1'b0;
      transferBusy             <= 1'b0;
    end else begin
      divided_origin_pulse_out <= origSync[1];
      transferBusy             <= (state != ST_IDLE) && (state != ST_INCR);
      if (state == ST_SER || state == ST_ALARM || state == ST_LOAD) begin
        divided_phase_a_out <= txLine;
        divided_phase_b_out <= 1'b0;
      end else if (state == ST_PULSE || state == ST_INCR) begin
        // gray sequence 00,10,11,01: A leads B forward
        divided_phase_a_out <= quadPhase[1] ^ quadPhase[0];
        divided_phase_b_out <= quadPhase[1];
      end else begin
        divided_phase_a_out <= 1'b1;
        divided_phase_b_out <= 1'b0;
      end
    end
  end
endmodule

// >>> alpo_position_output_sva.sv
// checker: timing relations on the position output pins
`timescale 1ns/10ps
module alpo_position_output_sva (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [1:0] encoder_usage_setting,
  input wire logic       sensor_power_on_command,
  input wire logic       alarmActive,
  input wire logic       divided_phase_a_out,
  input wire logic       divided_phase_b_out,
  input wire logic       transferBusy
);
  // ====================
  // helper logic
  localparam int MSG_CYC = alpo_pkg::MSG_LEN * alpo_pkg::FRAME_BITS * alpo_pkg::BIT_CYCLES;
  localparam int BIT_MIN = alpo_pkg::BIT_CYCLES - 1;
  wire         son  = sensor_power_on_command;
  wire         pa   = divided_phase_a_out;
  wire         pb   = divided_phase_b_out;
  wire         busy = transferBusy;
  logic [16:0] busyAge;
  logic [15:0] aRun;
  always_ff @(posedge clk) begin
    if (!reset_n || !busy) begin
      busyAge <= 17'h00000;
    end else if (busyAge != 17'h1FFFF) begin
      busyAge <= busyAge + 17'h00001;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n || $changed(pa)) begin
      aRun <= 16'h0001;
    end else if (aRun != 16'hFFFF) begin
      aRun <= aRun + 16'h0001;
    end
  end
  // ====================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // early cycles skipped: the line may still be leaving incremental levels
  wire serPhase = busy && busyAge > 32 && busyAge < MSG_CYC;
  chk_rise_starts: assert property (
    $rose(son) && !busy && encoder_usage_setting == alpo_pkg::USAGE_ABSOLUTE |-> ##[2:8] busy)
    else $error("busy did not follow sensor-on");
  chk_incr_refused: assert property (
    $rose(son) && encoder_usage_setting == alpo_pkg::USAGE_INCREMENT |-> (!busy) [*8])
    else $error("transfer started in incremental usage");
  chk_start_soon: assert property (
    $rose(busy) |-> ##[1:8] !pa)
    else $error("no start bit after busy");
  chk_bit_width: assert property (
    serPhase && $changed(pa) |-> aRun >= BIT_MIN)
    else $error("serial bit shorter than bit period");
  chk_b_quiet: assert property (
    busy && busyAge > 8 && busyAge < MSG_CYC |-> !pb)
    else $error("phase b moved during serial message");
  chk_quad_gray: assert property (
    $past(reset_n) |-> !($changed(pa) && $changed(pb)))
    else $error("both phases changed together");
  chk_step_spacing: assert property (
    $past(reset_n) && ($changed(pa) || $changed(pb)) && !(busy && busyAge < 32)
      |=> ($stable(pa) && $stable(pb)) [*3])
    else $error("quadrature steps closer than four cycles");
  chk_alarm_sends: assert property (
    $fell(son) && alarmActive && !busy |-> ##[2:8] busy)
    else $error("alarm message not started");
  cover property ($rose(busy));
  cover property (busyAge == 17'(MSG_CYC));
  cover property ($changed(pb) && !busy);
endmodule

bind alpo_position_output alpo_position_output_sva alpo_position_output_sva_inst (
  .clk, .reset_n, .encoder_usage_setting, .sensor_power_on_command, .alarmActive,
  .divided_phase_a_out, .divided_phase_b_out, .transferBusy
);

// >>> alpo_host_model.sv
// model: host serial receiver and quadrature counter on the divided outputs
`timescale 1ns/10ps
module alpo_host_model (
  input  wire logic              clk,
  input  wire logic              phaseA,
  input  wire logic              phaseB,
  input  wire logic              rxArm,
  output      logic [15:0][6:0]  rxLog,
  output      int                rxCount,
  output      int                rxErr,
  output      int                quadCount
);
  // ====================
  // quadrature counter, gray index {b, a^b}
  logic [1:0] prevIdx = 2'h1;
  logic [1:0] step;
  int         qCnt    = 0;
  assign quadCount = qCnt;
  always @(posedge clk) begin
    step = {phaseB, phaseA ^ phaseB} - prevIdx;
    if (step == 2'h1) qCnt++;
    if (step == 2'h3) qCnt--;
    prevIdx = {phaseB, phaseA ^ phaseB};
  end
  // ====================
  // serial receiver; armed only while a message is due, else pulses look like frames
  initial begin : rx_proc
    logic [7:0] sh;
    rxCount = 0;
    rxErr = 0;
    forever begin
      @(negedge phaseA iff rxArm);
      repeat (alpo_pkg::BIT_CYCLES / 2) @(posedge clk);
      if (phaseA !== 1'b0) rxErr++;
      for (int i = 0; i < 8; i++) begin
        repeat (alpo_pkg::BIT_CYCLES) @(posedge clk);
        sh[i] = phaseA;
      end
      repeat (alpo_pkg::BIT_CYCLES) @(posedge clk);
      if (phaseA !== 1'b1 || (^sh) !== 1'b0) rxErr++;
      rxLog[rxCount[3:0]] = sh[6:0];
      rxCount++;
    end
  end
endmodule

// >>> alpo_position_output_tb_top.sv
// testbench: position output block and the host model
`timescale 1ns/10ps
module alpo_position_output_tb_top;
  logic             clk;
  logic             reset_n;
  logic [35:0]      encoderPosition;
  logic [15:0]      resolution;
  logic [1:0]       usage;
  logic             direction;
  logic             sensorOn;
  logic             sensorOff;
  logic             alarmActive;
  logic [7:0]       alarmCode;
  logic             originPulse;
  logic             phaseA;
  logic             phaseB;
  logic             phaseC;
  logic             transferBusy;
  logic             rxArm;
  logic [15:0][6:0] rxLog;
  int               rxCount;
  int               rxErr;
  int               quadCount;
  logic             bLeak;
  int               cycleNo;
  int               rxAt [16];
  longint           hostUpper;
  longint           originPos;
  localparam int    FRAME_CYC = alpo_pkg::FRAME_BITS * alpo_pkg::BIT_CYCLES;
  int               nFail;
  int               checksDone;
  int               lowPart;
  alpo_position_output alpo_position_output_inst (
    .clk(clk), .reset_n(reset_n), .encoderPosition(encoderPosition),
    .divided_output_resolution_setting(resolution), .encoder_usage_setting(usage),
    .direction_selection_setting(direction), .sensor_power_on_command(sensorOn),
    .sensor_power_off_command(sensorOff), .alarmActive(alarmActive), .alarmCode(alarmCode),
    .originPulse(originPulse), .divided_phase_a_out(phaseA), .divided_phase_b_out(phaseB),
    .divided_origin_pulse_out(phaseC), .transferBusy(transferBusy)
  );
  alpo_host_model alpo_host_model_inst (
    .clk(clk), .phaseA(phaseA), .phaseB(phaseB), .rxArm(rxArm), .rxLog(rxLog),
    .rxCount(rxCount), .rxErr(rxErr), .quadCount(quadCount)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!reset_n) bLeak <= 1'b0;
    else if (rxArm && phaseB !== 1'b0) bLeak <= 1'b1;
  end
  // arrival cycle of every received character
  always @(posedge clk) cycleNo <= cycleNo + 1;
  always @(rxCount) rxAt[rxCount[3:0]] = cycleNo;
  // ====================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmpBit(input string what, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmpVal(input string what, input logic [35:0] exp, input logic [35:0] got);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // sel 0 waits for busy to equal goal, sel 1 for goal received characters
  task automatic waitUntil(input int sel, input int goal, input int lim);
    int n;
    n = 0;
    while (n < lim && (sel == 0 ? transferBusy !== 1'(goal) : rxCount < goal)) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      nFail++;
      $display("wrong value wait %0d expected %0d seen timeout", sel, goal);
      stopTest();
    end
  endtask
  task automatic doReset(input logic [1:0] u);
    reset_n = 1'b0;
    usage = u;
    sensorOn = 1'b0;
    tick(4);
    reset_n = 1'b1;
    tick(2);
    cmpBit("idle phase a", 1'b1, phaseA);
    cmpBit("idle phase b", 1'b0, phaseB);
  endtask
  // ====================
  // scenarios
  task automatic testIncrUsage();
    doReset(alpo_pkg::USAGE_INCREMENT);
    sensorOn = 1'b1;
    tick(200);
    cmpBit("busy in incremental usage", 1'b0, transferBusy);
    cmpBit("line in incremental usage", 1'b1, phaseA);
    sensorOn = 1'b0;
    tick(10);
    $display("test incremental usage finished");
  endtask
  // whole message passes the eight-word fifo with no frame time lost between characters
  task automatic testFifo();
    int gap;
    cmpVal("fifo chars passed", 36'(alpo_pkg::MSG_LEN), 36'(rxCount));
    for (int i = 2; i <= alpo_pkg::MSG_LEN; i++) begin
      gap = rxAt[i] - rxAt[i - 1];
      cmpBit("fifo char spacing", 1'b1, gap >= FRAME_CYC && gap <= FRAME_CYC + 3);
    end
    gap = rxAt[alpo_pkg::MSG_LEN] - rxAt[1];
    cmpBit("fifo message span", 1'b1, gap <= (alpo_pkg::MSG_LEN - 1) * (FRAME_CYC + 3));
    $display("test fifo finished");
  endtask
  task automatic testMessage();
    longint     scaled;
    longint     up;
    longint     mag;
    logic [6:0] exp [8];
    doReset(alpo_pkg::USAGE_ABSOLUTE);
    encoderPosition = 36'hFFFA0000A;
    scaled = longint'($signed(encoderPosition)) / longint'(resolution);
    up = scaled >>> 20;
    lowPart = int'(scaled & 64'h00000000000FFFFF);
    mag = (up < 0) ? -up : up;
    exp[0] = alpo_pkg::CH_P;
    exp[1] = (up < 0) ? alpo_pkg::CH_MINUS : alpo_pkg::CH_PLUS;
    for (int i = 0; i < 5; i++) begin
      exp[6 - i] = alpo_pkg::CH_ZERO + 7'(mag % 10);
      mag = mag / 10;
    end
    exp[7] = alpo_pkg::CH_CR;
    rxArm = 1'b1;
    sensorOn = 1'b1;
    waitUntil(1, 8, 90000);
    rxArm = 1'b0;
    for (int i = 0; i < 8; i++) cmpVal("message char", 36'(exp[i]), 36'(rxLog[i]));
    cmpVal("frame errors", 36'h000000000, 36'(rxErr));
    cmpVal("counts during message", 36'h000000000, 36'(quadCount));
    cmpBit("phase b during message", 1'b0, bLeak);
    waitUntil(0, 0, 2000);
    cmpVal("lower pulse count", 36'(lowPart), 36'(quadCount));
    cmpVal("rebuilt position", 36'(scaled), 36'(up * 1048576 + quadCount));
    hostUpper = up;
    originPos = up * 1048576 + quadCount;
    $display("test position message finished");
  endtask
  task automatic testIncremental();
    longint machPos;
    encoderPosition = encoderPosition + 36'h000000006;
    tick(40);
    // incremental steps follow unscaled position units
    cmpVal("forward steps", 36'(lowPart + 6), 36'(quadCount));
    machPos = hostUpper * 1048576 + quadCount - originPos;
    cmpVal("machine position", 36'h000000006, 36'(machPos));
    direction = 1'b1;
    encoderPosition = encoderPosition + 36'h000000006;
    tick(40);
    cmpVal("reversed steps", 36'(lowPart), 36'(quadCount));
    machPos = hostUpper * 1048576 + quadCount - originPos;
    cmpVal("reversed machine position", 36'h000000000, 36'(machPos));
    originPulse = 1'b1;
    tick(1);
    cmpBit("origin early", 1'b0, phaseC);
    tick(2);
    cmpBit("origin copy", 1'b1, phaseC);
    originPulse = 1'b0;
    $display("test incremental pulses finished");
  endtask
  task automatic testAlarm();
    alarmActive = 1'b1;
    rxArm = 1'b1;
    sensorOn = 1'b0;
    waitUntil(1, 9, 12000);
    rxArm = 1'b0;
    cmpVal("alarm first char", 36'(alpo_pkg::CH_A), 36'(rxLog[8]));
    cmpVal("alarm frame errors", 36'h000000000, 36'(rxErr));
    sensorOff = 1'b1;
    $display("test alarm finished");
  endtask
  initial begin
    nFail = 0;
    checksDone = 0;
    reset_n = 1'b0;
    encoderPosition = 36'h000000000;
    resolution = 16'h0002;
    usage = alpo_pkg::USAGE_ABSOLUTE;
    direction = 1'b0;
    sensorOn = 1'b0;
    sensorOff = 1'b0;
    alarmActive = 1'b0;
    alarmCode = 8'h42;
    originPulse = 1'b0;
    rxArm = 1'b0;
    testIncrUsage();
    testMessage();
    testFifo();
    testIncremental();
    testAlarm();
    stopTest();
  end
endmodule
